// [tb/pcm_encoder_model.sv]
// encoder pulse generator and machine contact model for the pulse counter
`timescale 1ns/1ns
module pcm_encoder_model (
  input  wire logic          mclk, // module clock
  output pcm_pkg::pcm_pins_s pins  // encoder lines and contacts
);
  // spacing of pin edges, wider than the synchroniser needs
  localparam int GAP = 6;

  initial pins = '0;

  task automatic set_pins(input logic [5:0] v);
    @(posedge mclk);
    pins <= v;
    repeat (GAP) @(posedge mclk);
  endtask

  task automatic contacts(input logic sel, input logic stop, input logic en);
    @(posedge mclk);
    pins.pulse_sel             <= sel;
    pins.count_stop_contact    <= stop;
    pins.marker_enable_contact <= en;
    repeat (GAP) @(posedge mclk);
  endtask

  // one gray step per count: up 00-10-11-01, down the reverse
  task automatic quad(input int n, input bit up);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      if (up) begin
        {pins.phase_a, pins.phase_b} <= {~pins.phase_b, pins.phase_a};
      end else begin
        {pins.phase_a, pins.phase_b} <= {pins.phase_b, ~pins.phase_a};
      end
      repeat (GAP) @(posedge mclk);
    end
  endtask

  // up pulses on phase a, down pulses on phase b
  task automatic ud(input int n, input bit up);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      if (up) pins.phase_a <= 1'b1;
      else pins.phase_b <= 1'b1;
      repeat (GAP) @(posedge mclk);
      pins.phase_a <= 1'b0;
      pins.phase_b <= 1'b0;
      repeat (GAP) @(posedge mclk);
    end
  endtask

  // one-cycle spike on phase a, shorter than the input filter accepts
  task automatic glitch();
    @(posedge mclk);
    pins.phase_a <= 1'b1;
    @(posedge mclk);
    pins.phase_a <= 1'b0;
    repeat (GAP) @(posedge mclk);
  endtask

  task automatic marker();
    @(posedge mclk);
    pins.marker_pulse_input <= 1'b1;
    repeat (GAP) @(posedge mclk);
    pins.marker_pulse_input <= 1'b0;
    repeat (GAP) @(posedge mclk);
  endtask
endmodule

// [tb/pulse_counter_compare_marker_test.sv]
// self-checking bench for the position pulse counter
`timescale 1ns/1ns
module pulse_counter_compare_marker_test;
  logic                       mclk;
  logic                       srst;
  wire pcm_pkg::pcm_pins_s    pins;
  logic [pcm_pkg::ADDR_W-1:0] addr;
  logic [pcm_pkg::DATA_W-1:0] wdata;
  logic                       wr;
  logic                       rd;
  logic [pcm_pkg::DATA_W-1:0] rdata;
  logic                       compare_out_a;
  logic                       compare_out_b;
  logic                       compare_out_c;
  logic [pcm_pkg::OUT_W-1:0]  partition_out;
  logic                       marker_hold_flag;
  pcm_pkg::pcm_lamps_s        lamps;
  logic [2:0]                 cmp3;
  int                         n_errors = 0;
  int                         samples_checked = 0;
  logic [7:0]                 pv [17] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h08, 8'h09, 8'h10, 8'h11, 8'h12, 8'h13, 8'h20, 8'h21, 8'hFF};
  logic [22:0]                cnt_tbl [7] = '{23'h0, 23'd10, 23'd11, 23'd95, 23'd160,
    23'd161, 23'h7FFFFF};

  pcm_counter i_pcm_counter (.mclk(mclk), .srst(srst), .pins(pins), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .compare_out_a(compare_out_a),
    .compare_out_b(compare_out_b), .compare_out_c(compare_out_c),
    .partition_out(partition_out), .marker_hold_flag(marker_hold_flag), .lamps(lamps));

  pcm_encoder_model i_enc (.mclk(mclk), .pins(pins));

  assign cmp3 = {compare_out_c, compare_out_b, compare_out_a};

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
      n_errors++;
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk(what, rdata, exp);
    @(negedge mclk);
    chk("rdata_idle", rdata, 32'h0);
  endtask

  task automatic settle();
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask

  // first ascending entry at or above the count, else the last partition
  function automatic logic [7:0] exp_part(input logic [22:0] c);
    int p;
    p = 16;
    for (int i = 15; i >= 0; i--) if (c <= 23'(10 * (i + 1))) p = i;
    return pv[p];
  endfunction

  initial begin
    logic [2:0] e;
    logic [7:0] ep;
    srst  = 1'b1;
    addr  = '0;
    wdata = '0;
    wr    = 1'b0;
    rd    = 1'b0;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    rchk("count_rst", pcm_pkg::OFS_COUNT, 32'h0);
    rchk("unmapped", 8'h3C, 32'h0);
    i_enc.contacts(1'b1, 1'b0, 1'b0);
    i_enc.quad(4, 1'b1);
    rchk("quad_up", pcm_pkg::OFS_COUNT, 32'h4);
    i_enc.quad(2, 1'b0);
    rchk("quad_down", pcm_pkg::OFS_COUNT, 32'h2);
    i_enc.set_pins(6'b111101);
    settle();
    chk("lamps_a", 32'(lamps[12:8]), 32'h17);
    i_enc.quad(2, 1'b1);
    settle();
    chk("lamps_b", 32'(lamps[12:8]), 32'h0F);
    rchk("frozen", pcm_pkg::OFS_COUNT, 32'h2);
    i_enc.set_pins(6'b010000);
    i_enc.set_pins(6'b000000);
    i_enc.ud(3, 1'b1);
    i_enc.ud(1, 1'b0);
    rchk("updown", pcm_pkg::OFS_COUNT, 32'h4);
    i_enc.glitch();
    rchk("glitch", pcm_pkg::OFS_COUNT, 32'h4);
    wr_reg(pcm_pkg::OFS_COUNT, 32'h7FFFFF);
    i_enc.ud(1, 1'b1);
    rchk("wrap_up", pcm_pkg::OFS_COUNT, 32'h0);
    i_enc.ud(1, 1'b0);
    rchk("wrap_down", pcm_pkg::OFS_COUNT, 32'h7FFFFF);
    // mode a thresholds, count sits on register a
    wr_reg(pcm_pkg::OFS_COMPARE_OUT_A, 32'd10);
    wr_reg(pcm_pkg::OFS_COMPARE_OUT_B, 32'd20);
    wr_reg(pcm_pkg::OFS_COMPARE_OUT_C, 32'd5);
    wr_reg(pcm_pkg::OFS_COUNT, 32'd10);
    for (int p = 0; p < 8; p++) begin
      wr_reg(pcm_pkg::OFS_CTRL, 32'(p) << pcm_pkg::CTL_POL_A);
      settle();
      e = {~p[2], p[1], p[0]};
      chk("cmp_out", 32'(cmp3), 32'(e));
      chk("cmp_part", 32'(partition_out), 32'(e));
      chk("cmp_lamps", 32'(lamps.lamp_out), 32'(e));
    end
    wr_reg(pcm_pkg::OFS_CTRL, 32'h0);
    wr_reg(pcm_pkg::OFS_COUNT, 32'd11);
    settle();
    chk("cmp_above", 32'({compare_out_c, compare_out_b, compare_out_a}), 32'h5);
    // mode a marker preset and hold
    wr_reg(pcm_pkg::OFS_PRESET, 32'h123);
    wr_reg(pcm_pkg::OFS_CTRL, 32'h2);
    i_enc.contacts(1'b1, 1'b0, 1'b1);
    i_enc.marker();
    rchk("mk_load", pcm_pkg::OFS_COUNT, 32'h123);
    chk("hold_set", 32'(marker_hold_flag), 32'h1);
    i_enc.quad(1, 1'b1);
    i_enc.marker();
    rchk("mk_held", pcm_pkg::OFS_COUNT, 32'h124);
    wr_reg(pcm_pkg::OFS_CTRL, 32'h6);
    settle();
    chk("hold_clr", 32'(marker_hold_flag), 32'h0);
    wr_reg(pcm_pkg::OFS_CTRL, 32'h2);
    i_enc.contacts(1'b1, 1'b0, 1'b0);
    i_enc.marker();
    rchk("mk_disabled", pcm_pkg::OFS_COUNT, 32'h124);
    i_enc.contacts(1'b1, 1'b0, 1'b1);
    i_enc.marker();
    chk("hold_again", 32'(marker_hold_flag), 32'h1);
    wr_reg(pcm_pkg::OFS_CTRL, 32'h0);
    settle();
    chk("hold_sync", 32'(marker_hold_flag), 32'h0);
    // mode b partition lookup
    wr_reg(pcm_pkg::OFS_CTRL, 32'h1);
    for (int i = 0; i < 16; i++) begin
      wr_reg(pcm_pkg::OFS_TBL + 8'(4 * i), 32'(10 * (i + 1)));
    end
    for (int p = 0; p < 17; p++) wr_reg(pcm_pkg::OFS_PART + 8'(4 * p), 32'(pv[p]));
    foreach (cnt_tbl[k]) begin
      wr_reg(pcm_pkg::OFS_COUNT, 32'(cnt_tbl[k]));
      settle();
      ep = exp_part(cnt_tbl[k]);
      chk("part_out", 32'(partition_out), 32'(ep));
      chk("part_lamps", 32'(lamps.lamp_out), 32'(ep));
      chk("b_cmp_low", 32'({compare_out_c, compare_out_b, compare_out_a}), 32'h0);
    end
    // mode b marker preset, hold ignores the clear bit
    wr_reg(pcm_pkg::OFS_PRESET, 32'd55);
    wr_reg(pcm_pkg::OFS_CTRL, 32'h3);
    i_enc.marker();
    rchk("b_mk_load", pcm_pkg::OFS_COUNT, 32'd55);
    chk("b_part", 32'(partition_out), 32'(pv[5]));
    rchk("b_status", pcm_pkg::OFS_STATUS, 32'h05D8);
    wr_reg(pcm_pkg::OFS_CTRL, 32'h7);
    settle();
    chk("b_hold_kept", 32'(marker_hold_flag), 32'h1);
    wr_reg(pcm_pkg::OFS_CTRL, 32'h2);
    settle();
    chk("b_sticky", 32'(partition_out), 32'(pv[5]));
    wr_reg(pcm_pkg::OFS_CTRL, 32'h0);
    settle();
    chk("b_hold_clr", 32'(marker_hold_flag), 32'h0);
    // mid-run reset with phase a parked high: no phantom count on release
    @(posedge mclk);
    srst <= 1'b1;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    settle();
    chk("rst_lamps", 32'(lamps[12:8]), 32'h11);
    chk("rst_part", 32'(partition_out), 32'h0);
    rchk("rst_count", pcm_pkg::OFS_COUNT, 32'h0);
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    give_verdict();
  end
endmodule

// [verilog/pcm_counter.sv]
// position pulse counter with mode a/b comparison and marker preset
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
// Behaviour
// - mode b: first table entry >= count wins
// - equal count selects same-numbered partition
// - sixteen comparison entries, index 0 to 15
// - eight outputs carry selected partition byte
// - select high (open): quadrature decoding
// - select low: separate up/down pulses
// - quadrature counts every edge of both phases
// - a leading counts up, b leading down
// - up pulse increments, down pulse decrements
// - count stop closed freezes the counter; a qualified marker preset and count register writes still load
// - markers ignored unless marker enable closed
// - mode a: first qualified marker loads preset
// - mode a: hold set, cleared by clear/sync
// - mode b: first qualified marker loads preset
// - mode b: hold cleared only by sync low
// - mode a: three outputs with selectable polarity
// - phase lamps follow phase inputs
// - marker lamp follows marker input
// - stop lamp follows count stop contact
// - enable lamp follows marker enable contact
// - mode a: lamps 0..2 mirror a, b, c
// - polarity 0: out high when count exceeds
// - 23-bit unsigned up/down counter
module pcm_counter #(
  parameter int CNT_W   = pcm_pkg::CNT_W,
  parameter int NUM_CMP = pcm_pkg::NUM_CMP
) (
  input  wire logic                         mclk,          // 50 MHz clock
  input  wire logic                         srst,          // sync reset, high
  input  wire pcm_pkg::pcm_pins_s           pins,          // encoder and contacts
  input  wire logic [pcm_pkg::ADDR_W-1:0]   addr,          // register byte address
  input  wire logic [pcm_pkg::DATA_W-1:0]   wdata,         // write data
  input  wire logic                         wr,            // write strobe
  input  wire logic                         rd,            // read strobe
  output logic      [pcm_pkg::DATA_W-1:0]   rdata,         // read data, next cycle
  output logic                              compare_out_a, // mode a output a
  output logic                              compare_out_b, // mode a output b
  output logic                              compare_out_c, // mode a output c
  output logic      [pcm_pkg::OUT_W-1:0]    partition_out, // mode b partition byte
  output logic                              marker_hold_flag, // marker hold
  output pcm_pkg::pcm_lamps_s               lamps          // indicator lamps
);
  localparam int NP  = NUM_CMP + 1;
  localparam int IXW = $clog2(NP);

  if (CNT_W != pcm_pkg::CNT_W || NUM_CMP != pcm_pkg::NUM_CMP) begin : g_chk
    $error("pcm_counter: only the documented width and table size are supported");
  end

  // input synchronisers: three stages, change taken when stages 2 and 3 agree
  logic [pcm_pkg::SYNC_N-1:0] s1, s2, s3, filt, filt_d;
  genvar gi;
  for (gi = 0; gi < pcm_pkg::SYNC_N; gi++) begin : g_sync
    always_ff @(posedge mclk) begin
      if (srst) begin
        // keeps sampling in reset: a parked encoder gives no false edge on release
        s1[gi]     <= pins[gi];
        s2[gi]     <= s1[gi];
        s3[gi]     <= s2[gi];
        filt[gi]   <= s2[gi];
        filt_d[gi] <= s2[gi];
      end else begin
        s1[gi] <= pins[gi];
        s2[gi] <= s1[gi];
        s3[gi] <= s2[gi];
        if (s2[gi] == s3[gi]) begin
          filt[gi] <= s3[gi];
        end
        filt_d[gi] <= filt[gi];
      end
    end
  end

  pcm_pkg::pcm_pins_s pf, pd;
  assign pf = pcm_pkg::pcm_pins_s'(filt);
  assign pd = pcm_pkg::pcm_pins_s'(filt_d);

  // quadrature step: {up, down} from previous and current {a, b}
  function automatic logic [1:0] quad_step(input logic [1:0] prv, input logic [1:0] cur);
    logic [1:0] r;
    r = 2'b00;
    case ({prv, cur})
      4'b0010, 4'b1011, 4'b1101, 4'b0100: r = 2'b10;
      4'b0001, 4'b0111, 4'b1110, 4'b1000: r = 2'b01;
      default:                            r = 2'b00;
    endcase
    return r;
  endfunction

  // registers
  logic                 mode_b, sync_req, hold_clr, pol_a, pol_b, pol_c;
  logic [CNT_W-1:0]     cnt, next_cnt, preset, cmp_a, cmp_b, cmp_c;
  logic [CNT_W-1:0]     tbl [NUM_CMP];
  logic [7:0]           part [NP];

  logic                 wr_ctrl, wr_count, step_up, step_dn, mk_rise, marker_load;
  logic [IXW-1:0]       sel_idx;
  logic [1:0]           qd;
  logic [7:0]           tbl_ix, part_ix;

  assign wr_ctrl  = wr && addr == pcm_pkg::OFS_CTRL;
  assign wr_count = wr && addr == pcm_pkg::OFS_COUNT;
  assign tbl_ix   = (addr - pcm_pkg::OFS_TBL) >> 2;
  assign part_ix  = (addr - pcm_pkg::OFS_PART) >> 2;

  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_b   <= 1'b0;
      sync_req <= 1'b0;
      hold_clr <= 1'b0;
      pol_a    <= 1'b0;
      pol_b    <= 1'b0;
      pol_c    <= 1'b0;
    end else if (wr_ctrl) begin
      // mode b once entered is kept until reset
      mode_b   <= mode_b | wdata[pcm_pkg::CTL_MODE_B];
      sync_req <= wdata[pcm_pkg::CTL_SYNC];
      hold_clr <= wdata[pcm_pkg::CTL_HCLR];
      pol_a    <= wdata[pcm_pkg::CTL_POL_A];
      pol_b    <= wdata[pcm_pkg::CTL_POL_B];
      pol_c    <= wdata[pcm_pkg::CTL_POL_C];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      preset <= pcm_pkg::RST_CNT;
      cmp_a  <= pcm_pkg::RST_CMP;
      cmp_b  <= pcm_pkg::RST_CMP;
      cmp_c  <= pcm_pkg::RST_CMP;
    end else if (wr) begin
      case (addr)
        pcm_pkg::OFS_PRESET: preset <= wdata[CNT_W-1:0];
        pcm_pkg::OFS_COMPARE_OUT_A:   cmp_a  <= wdata[CNT_W-1:0];
        pcm_pkg::OFS_COMPARE_OUT_B:   cmp_b  <= wdata[CNT_W-1:0];
        pcm_pkg::OFS_COMPARE_OUT_C:   cmp_c  <= wdata[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  for (gi = 0; gi < NUM_CMP; gi++) begin : g_tbl
    always_ff @(posedge mclk) begin
      if (srst) begin
        tbl[gi] <= pcm_pkg::RST_CMP;
      end else if (wr && addr >= pcm_pkg::OFS_TBL && addr < pcm_pkg::OFS_PART &&
                   addr[1:0] == 2'b00 && tbl_ix == 8'(gi)) begin
        tbl[gi] <= wdata[CNT_W-1:0];
      end
    end
  end

  for (gi = 0; gi < NP; gi++) begin : g_part
    always_ff @(posedge mclk) begin
      if (srst) begin
        part[gi] <= pcm_pkg::RST_PART;
      end else if (wr && addr >= pcm_pkg::OFS_PART && addr <= pcm_pkg::OFS_PART_L &&
                   addr[1:0] == 2'b00 && part_ix == 8'(gi)) begin
        part[gi] <= wdata[7:0];
      end
    end
  end

  // count direction from the selected pulse type
  assign qd = quad_step({pd.phase_a, pd.phase_b}, {pf.phase_a, pf.phase_b});
  always_comb begin
    if (pf.pulse_sel) begin
      step_up = qd[1];
      step_dn = qd[0];
    end else begin
      step_up = pf.phase_a & ~pd.phase_a;
      step_dn = pf.phase_b & ~pd.phase_b;
    end
  end

  // marker qualification: first rising edge with sync request and enable
  assign mk_rise     = pf.marker_pulse_input & ~pd.marker_pulse_input;
  assign marker_load = mk_rise && pf.marker_enable_contact && sync_req &&
                       !marker_hold_flag && !wr_count;

  always_comb begin
    next_cnt = cnt;
    if (wr_count) begin
      next_cnt = wdata[CNT_W-1:0];
    end else if (marker_load) begin
      next_cnt = preset;
    end else if (!pf.count_stop_contact) begin
      if (step_up && !step_dn) begin
        next_cnt = cnt + 1'b1;
      end else if (step_dn && !step_up) begin
        next_cnt = cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt <= pcm_pkg::RST_CNT;
    end else begin
      cnt <= next_cnt;
    end
  end

  // hold flag: set wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      marker_hold_flag <= 1'b0;
    end else if (marker_load) begin
      marker_hold_flag <= 1'b1;
    end else if (!sync_req || (!mode_b && hold_clr)) begin
      marker_hold_flag <= 1'b0;
    end
  end

  // partition lookup; relies on an ascending table
  always_comb begin
    sel_idx = IXW'(NUM_CMP);
    for (int i = NUM_CMP - 1; i >= 0; i--) begin
      if (tbl[i] >= cnt) begin
        sel_idx = IXW'(i);
      end
    end
  end

  logic ca, cb, cc;
  assign ca = (cnt > cmp_a) ^ pol_a;
  assign cb = (cnt > cmp_b) ^ pol_b;
  assign cc = (cnt > cmp_c) ^ pol_c;

  always_ff @(posedge mclk) begin
    if (srst) begin
      compare_out_a <= 1'b0;
      compare_out_b <= 1'b0;
      compare_out_c <= 1'b0;
      partition_out <= 8'h00;
    end else if (mode_b) begin
      compare_out_a <= 1'b0;
      compare_out_b <= 1'b0;
      compare_out_c <= 1'b0;
      partition_out <= part[sel_idx];
    end else begin
      compare_out_a <= ca;
      compare_out_b <= cb;
      compare_out_c <= cc;
      partition_out <= {5'h00, cc, cb, ca};
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      lamps <= '0;
    end else begin
      lamps.lamp_a      <= pf.phase_a;
      lamps.lamp_b      <= pf.phase_b;
      lamps.lamp_marker <= pf.marker_pulse_input;
      lamps.lamp_stop   <= pf.count_stop_contact;
      lamps.lamp_enable <= pf.marker_enable_contact;
      lamps.lamp_out    <= mode_b ? part[sel_idx] : {5'h00, cc, cb, ca};
    end
  end

  // register read port
  logic [pcm_pkg::DATA_W-1:0] rd_val;
  always_comb begin
    rd_val = '0;
    case (addr)
      pcm_pkg::OFS_CTRL: begin
        rd_val[pcm_pkg::CTL_MODE_B] = mode_b;
        rd_val[pcm_pkg::CTL_SYNC]   = sync_req;
        rd_val[pcm_pkg::CTL_HCLR]   = hold_clr;
        rd_val[pcm_pkg::CTL_POL_A]  = pol_a;
        rd_val[pcm_pkg::CTL_POL_B]  = pol_b;
        rd_val[pcm_pkg::CTL_POL_C]  = pol_c;
      end
      pcm_pkg::OFS_PRESET: rd_val[CNT_W-1:0] = preset;
      pcm_pkg::OFS_COUNT:  rd_val[CNT_W-1:0] = cnt;
      pcm_pkg::OFS_COMPARE_OUT_A:   rd_val[CNT_W-1:0] = cmp_a;
      pcm_pkg::OFS_COMPARE_OUT_B:   rd_val[CNT_W-1:0] = cmp_b;
      pcm_pkg::OFS_COMPARE_OUT_C:   rd_val[CNT_W-1:0] = cmp_c;
      pcm_pkg::OFS_STATUS: begin
        rd_val[pcm_pkg::ST_CMP_A]  = compare_out_a;
        rd_val[pcm_pkg::ST_CMP_B]  = compare_out_b;
        rd_val[pcm_pkg::ST_CMP_C]  = compare_out_c;
        rd_val[pcm_pkg::ST_HOLD]   = marker_hold_flag;
        rd_val[pcm_pkg::ST_MEN]    = pf.marker_enable_contact;
        rd_val[pcm_pkg::ST_STOP]   = pf.count_stop_contact;
        rd_val[pcm_pkg::ST_MODE_B] = mode_b;
        rd_val[pcm_pkg::ST_PSEL]   = pf.pulse_sel;
        rd_val[pcm_pkg::ST_OUT_LO +: 8] = partition_out;
      end
      default: begin
        if (addr[1:0] == 2'b00 && addr >= pcm_pkg::OFS_TBL && addr < pcm_pkg::OFS_PART) begin
          rd_val[CNT_W-1:0] = tbl[tbl_ix[3:0]];
        end else if (addr[1:0] == 2'b00 && addr >= pcm_pkg::OFS_PART &&
                     addr <= pcm_pkg::OFS_PART_L) begin
          rd_val[7:0] = part[part_ix[4:0]];
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata <= '0;
    end else begin
      rdata <= rd ? rd_val : '0;
    end
  end

  // checks
  stop_hold_a: assert property (@(posedge mclk) disable iff (srst)
    pf.count_stop_contact && !wr_count && !marker_load |=> cnt == $past(cnt))
    else $error("counter moved during count stop");

  marker_load_a: assert property (@(posedge mclk) disable iff (srst)
    marker_load |=> cnt == $past(preset) && marker_hold_flag)
    else $error("marker edge did not load preset and set hold");

  marker_ign_a: assert property (@(posedge mclk) disable iff (srst)
    !pf.marker_enable_contact || !sync_req |-> !marker_load)
    else $error("marker accepted while not enabled");

  hold_clr_a_a: assert property (@(posedge mclk) disable iff (srst)
    !mode_b && hold_clr && !marker_load |=> !marker_hold_flag)
    else $error("hold flag not cleared in mode a");

  hold_mode_b_a: assert property (@(posedge mclk) disable iff (srst)
    mode_b && sync_req && marker_hold_flag && !wr_ctrl |=> marker_hold_flag)
    else $error("hold flag cleared while sync request held");

  quad_up_a: assert property (@(posedge mclk) disable iff (srst)
    pf.pulse_sel && !pf.count_stop_contact && !wr_count && !marker_load &&
    pd.phase_a == pd.phase_b && pf.phase_a != pd.phase_a && pf.phase_b == pd.phase_b
    |=> cnt == $past(cnt) + 1'b1)
    else $error("a-leading edge did not count up");

  updown_dn_a: assert property (@(posedge mclk) disable iff (srst)
    !pf.pulse_sel && !pf.count_stop_contact && !wr_count && !marker_load &&
    step_dn && !step_up |=> cnt == $past(cnt) - 1'b1)
    else $error("down pulse did not decrement");

  cmp_pol_a: assert property (@(posedge mclk) disable iff (srst)
    !mode_b && !wr_ctrl |=> compare_out_a == (($past(cnt) > $past(cmp_a)) ^ $past(pol_a)))
    else $error("compare output a wrong");

  part_eq_a: assert property (@(posedge mclk) disable iff (srst)
    mode_b && cnt == tbl[0] |=> partition_out == $past(part[0]))
    else $error("equal count did not pick partition 0");

  part_top_a: assert property (@(posedge mclk) disable iff (srst)
    mode_b && cnt > tbl[NUM_CMP-1] && tbl[0] < tbl[NUM_CMP-1]
    |=> partition_out == $past(part[NUM_CMP]))
    else $error("count above table did not pick last partition");

  stop_lamp_a: assert property (@(posedge mclk) disable iff (srst)
    1'b1 |=> lamps.lamp_stop == $past(pf.count_stop_contact))
    else $error("stop lamp mismatch");

  cov_quad_c:   cover property (@(posedge mclk) disable iff (srst) pf.pulse_sel && step_up);
  cov_marker_c: cover property (@(posedge mclk) disable iff (srst) marker_load);
  cov_top_c:    cover property (@(posedge mclk) disable iff (srst)
    mode_b && sel_idx == IXW'(NUM_CMP));
  cov_stop_c:   cover property (@(posedge mclk) disable iff (srst)
    pf.count_stop_contact && step_up);
endmodule

// [verilog/pcm_pkg.sv]
// constants, register map and pin group for the position pulse counter
package pcm_pkg;
  localparam int          CNT_W      = 23;
  localparam int          NUM_CMP    = 16;
  localparam int          NUM_PART   = 17;
  localparam int          OUT_W      = 8;
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;
  localparam int          SYNC_N     = 6;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_PRESET = 8'h04;
  localparam logic [7:0]  OFS_COUNT  = 8'h08;
  localparam logic [7:0]  OFS_STATUS = 8'h0C;
  localparam logic [7:0]  OFS_COMPARE_OUT_A   = 8'h10;
  localparam logic [7:0]  OFS_COMPARE_OUT_B   = 8'h14;
  localparam logic [7:0]  OFS_COMPARE_OUT_C   = 8'h18;
  localparam logic [7:0]  OFS_TBL    = 8'h40;
  localparam logic [7:0]  OFS_PART   = 8'h80;
  localparam logic [7:0]  OFS_PART_L = 8'hC0;
  // control register fields
  localparam int          CTL_MODE_B = 0;
  localparam int          CTL_SYNC   = 1;
  localparam int          CTL_HCLR   = 2;
  localparam int          CTL_POL_A  = 3;
  localparam int          CTL_POL_B  = 4;
  localparam int          CTL_POL_C  = 5;
  // status register fields
  localparam int          ST_CMP_A   = 0;
  localparam int          ST_CMP_B   = 1;
  localparam int          ST_CMP_C   = 2;
  localparam int          ST_HOLD    = 3;
  localparam int          ST_MEN     = 4;
  localparam int          ST_STOP    = 5;
  localparam int          ST_MODE_B  = 6;
  localparam int          ST_PSEL    = 7;
  localparam int          ST_OUT_LO  = 8;
  // reset values
  localparam logic [22:0] RST_CNT    = 23'h000000;
  localparam logic [22:0] RST_CMP    = 23'h000000;
  localparam logic [7:0]  RST_PART   = 8'h00;

  typedef struct packed {
    logic pulse_sel;             // 1 open: quadrature, 0 tied low: up/down
    logic count_stop_contact;    // 1 closed
    logic marker_enable_contact; // 1 closed
    logic marker_pulse_input;
    logic phase_b;               // phase b or down pulse
    logic phase_a;               // phase a or up pulse
  } pcm_pins_s;

  typedef struct packed {
    logic lamp_a;
    logic lamp_b;
    logic lamp_marker;
    logic lamp_stop;
    logic lamp_enable;
    logic [7:0] lamp_out;
  } pcm_lamps_s;
endpackage
